// file: phy_status_debug_observer_regs.svh
// bit positions, reset values and widths for the status lamps and debug bus
`ifndef PHY_STATUS_DEBUG_OBSERVER_REGS_SVH
`define PHY_STATUS_DEBUG_OBSERVER_REGS_SVH

`define LAMP_W          8
`define LAMP_ORIENT_HI0 0
`define LAMP_ORIENT_HI1 1
`define LAMP_ONE_LANE   2
`define LAMP_PORT_INIT  3
`define LAMP_LINK_INIT  4
`define LAMP_CLK_LOCK   5
`define LAMP_SIM_ERR    6
`define LAMP_SIM_DONE   7
`define LAMP_RST        8'h03

`define DBG_W           224
`define DBG_RST         224'h0
`define DBG_IDLE2       0
`define DBG_MODE_1X     1
`define DBG_IDLE1       2
`define DBG_PORT_INIT   3
`define DBG_RX_LANE_R   4
`define DBG_CHBOND_EN   5
`define DBG_ALIGN_LO    10
`define DBG_COMMA_LO    14
`define DBG_INHIBIT_LO  30
`define DBG_RX_RST_REQ  34
`define DBG_NX_ALIGNED  35
`define DBG_NX_READY    36
`define DBG_1X_DETECT   37
`define DBG_STATE_LO    38
`define DBG_OUT_SYNC    42
`define DBG_SENT_LO     96
`define DBG_INIT_SENT   103
`define DBG_SEND_LREQ   104
`define DBG_LINK_RST    105
`define DBG_STOP_LO     160
`define DBG_CAUSE_LO    192
`define DBG_ERRDET_LO   197
`define DBG_FRAME_LO    201

`define LANES           4
`define COMMA_W         16
`define CAUSE_W         5

`endif

// file: phy_status_pkg.sv
// types carried by the status and debug observer
package phy_status_pkg;

    typedef enum logic [2:0] {
        INIT_SILENT,
        INIT_SEEK,
        INIT_SYNC_WAIT,
        INIT_LANE_PROBE,
        INIT_RX_RESET,
        INIT_MULTILANE,
        INIT_SINGLE_LANE_ZERO,
        INIT_SINGLE_LANE_REDUNDANT
    } initState_t;

    typedef struct packed {
        logic [3:0]  chanAligned;
        logic [15:0] charIsComma;
        logic [3:0]  txInhibit;
        logic [3:0]  laneSync;
        logic        rxResetReq;
        logic        nxAligned;
        logic        nxReady;
        logic        oneLaneDetect;
        logic        outOfSync;
    } laneStatus_t;

    // order: packet accepted down to restart-from-retry
    typedef struct packed {
        logic pktAccepted;
        logic multicastEvt;
        logic linkResponse;
        logic pktRetry;
        logic pktNotAccepted;
        logic linkRequest;
        logic restartFromRetry;
    } ctrlSymSent_t;

    // order: input retry stop down to send not-accepted
    typedef struct packed {
        logic inRetryStop;
        logic inErrorStop;
        logic outRetryStop;
        logic outErrorStop;
        logic retryDetect;
        logic sendRetry;
        logic notAcceptDetect;
        logic sendNotAccept;
    } recovery_t;

    typedef struct packed {
        logic inRecoverable;
        logic inRetry;
        logic outRecoverable;
        logic outFatal;
    } errDetect_t;

    typedef struct packed {
        logic discontinue;
        logic eop;
        logic sop;
        logic inPacket;
    } rxFraming_t;

endpackage

// file: phy_status_debug_observer.sv
// status lamp driver and debug bus assembly for the serial link physical layer
`timescale 1ns/1ns
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// - lamp bits 0 and 1 always one
// - lamp bits 6 and 7 zero in hardware
// - lamp bit 2 shows single lane configuration
// - lamp 3 port init; link needs port
// - lamp bit 4 shows link up
// - lamp bit 5 shows clock lock
// - simulation: bit 6 error, bit 7 done
// - debug 0..3 idle, mode, port; 5 bond
// - debug 4 set in redundant lane state
// - debug 41:38 carry init state code
// - align, comma, inhibit per lane fields
// - debug 96..102 flag sent control symbols
// - debug 103..105 initial, pending request, reset
// - debug 160..167 retry and stop states
// - debug 196:192 outgoing not-accepted cause
// - debug 197..200 error detect flags
// - debug 201..204 outbound receive framing
`include "phy_status_debug_observer_regs.svh"

module phy_status_debug_observer
    import phy_status_pkg::*;
#(
    parameter bit SIM_BUILD = 1'b0
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clkEn,
    input  wire logic                 singleLaneConfigured,
    input  wire logic                 portInitialized,
    input  wire logic                 linkInitialized,
    input  wire logic                 clockLocked,
    input  wire logic                 simSelfCheckErr,
    input  wire logic                 simExerciseDone,
    input  wire logic                 idle2Selected,
    input  wire logic                 idle1Selected,
    input  wire initState_t           initState,
    input  wire laneStatus_t          laneStatus,
    input  wire ctrlSymSent_t         ctrlSymSent,
    input  wire logic                 initialSymSent,
    input  wire logic                 linkReqPending,
    input  wire logic                 linkReset,
    input  wire recovery_t            recovery,
    input  wire logic [`CAUSE_W-1:0]  notAcceptCause,
    input  wire errDetect_t           errDetect,
    input  wire rxFraming_t           outboundLinkManagerRx,
    output logic [`LAMP_W-1:0]        status_lamp_bank,
    output logic [`DBG_W-1:0]         phyDebug
);

    // ****************************************************************
    // state decode
    // ****************************************************************
    logic redundantLane;
    logic oneLaneMode;

    always_comb begin
        redundantLane = 1'b0;
        oneLaneMode   = 1'b0;
        case (initState)
            INIT_SINGLE_LANE_ZERO: begin
                oneLaneMode = 1'b1;
            end
            INIT_SINGLE_LANE_REDUNDANT: begin
                redundantLane = 1'b1;
                oneLaneMode   = 1'b1;
            end
            default: begin
                redundantLane = 1'b0;
                oneLaneMode   = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // status lamps
    // ****************************************************************
    logic simErrLamp;
    logic simDoneLamp;
    logic laneLamp_r;
    logic portLamp_r;
    logic linkLamp_r;
    logic lockLamp_r;
    logic simErrLamp_r;
    logic simDoneLamp_r;

    // sim-only lamps compile out to zero in hardware builds
    assign simErrLamp  = SIM_BUILD ? simSelfCheckErr : 1'b0;
    assign simDoneLamp = SIM_BUILD ? simExerciseDone : 1'b0;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            laneLamp_r <= 1'b0;
            portLamp_r <= 1'b0;
        end else if (clkEn) begin
            laneLamp_r <= singleLaneConfigured;
            portLamp_r <= portInitialized;
        end
    end

    // link lamp gated by port so a stale link flag never shows alone
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            linkLamp_r <= 1'b0;
        end else if (clkEn) begin
            linkLamp_r <= linkInitialized & portInitialized;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockLamp_r <= 1'b0;
        end else if (clkEn) begin
            lockLamp_r <= clockLocked;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            simErrLamp_r  <= 1'b0;
            simDoneLamp_r <= 1'b0;
        end else if (clkEn) begin
            simErrLamp_r  <= simErrLamp;
            simDoneLamp_r <= simDoneLamp;
        end
    end

    // ****************************************************************
    // lamp assembly
    // ****************************************************************
    // orientation lamps are wired, so they read one even in reset
    always_comb begin
        status_lamp_bank                   = `LAMP_RST;
        status_lamp_bank[`LAMP_ORIENT_HI0] = 1'b1;
        status_lamp_bank[`LAMP_ORIENT_HI1] = 1'b1;
        status_lamp_bank[`LAMP_ONE_LANE]   = laneLamp_r;
        status_lamp_bank[`LAMP_PORT_INIT]  = portLamp_r;
        status_lamp_bank[`LAMP_LINK_INIT]  = linkLamp_r;
        status_lamp_bank[`LAMP_CLK_LOCK]   = lockLamp_r;
        status_lamp_bank[`LAMP_SIM_ERR]    = simErrLamp_r;
        status_lamp_bank[`LAMP_SIM_DONE]   = simDoneLamp_r;
    end

    // ****************************************************************
    // debug bus, initialisation flags
    // ****************************************************************
    logic [1:0] idleSel_r;
    logic       oneLane_r;
    logic       redundant_r;
    logic       portDbg_r;
    logic       bondEn_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idleSel_r <= 2'h0;
            portDbg_r <= 1'b0;
        end else if (clkEn) begin
            idleSel_r <= {idle1Selected, idle2Selected};
            portDbg_r <= portInitialized;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            oneLane_r   <= 1'b0;
            redundant_r <= 1'b0;
        end else if (clkEn) begin
            oneLane_r   <= oneLaneMode;
            redundant_r <= redundantLane;
        end
    end

    // bonding only makes sense once every lane holds sync
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bondEn_r <= 1'b0;
        end else if (clkEn) begin
            bondEn_r <= &laneStatus.laneSync;
        end
    end

    // ****************************************************************
    // debug bus, per-lane transceiver fields
    // ****************************************************************
    logic [`LANES-1:0]   align_r;
    logic [`COMMA_W-1:0] comma_r;
    logic [`LANES-1:0]   inhibit_r;
    logic [3:0]          laneFlags_r;
    logic                outOfSync_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            align_r   <= '0;
            comma_r   <= '0;
            inhibit_r <= '0;
        end else if (clkEn) begin
            align_r   <= laneStatus.chanAligned;
            comma_r   <= laneStatus.charIsComma;
            inhibit_r <= laneStatus.txInhibit;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            laneFlags_r <= 4'h0;
            outOfSync_r <= 1'b0;
        end else if (clkEn) begin
            laneFlags_r <= {laneStatus.oneLaneDetect, laneStatus.nxReady,
                            laneStatus.nxAligned, laneStatus.rxResetReq};
            outOfSync_r <= laneStatus.outOfSync;
        end
    end

    // ****************************************************************
    // debug bus, initialisation state
    // ****************************************************************
    initState_t state_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= INIT_SILENT;
        end else if (clkEn) begin
            state_r <= initState;
        end
    end

    // ****************************************************************
    // debug bus, control symbols
    // ****************************************************************
    ctrlSymSent_t sent_r;
    logic         initSent_r;
    logic         lreqPend_r;
    logic         linkRst_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sent_r <= '0;
        end else if (clkEn) begin
            sent_r <= ctrlSymSent;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            initSent_r <= 1'b0;
            lreqPend_r <= 1'b0;
            linkRst_r  <= 1'b0;
        end else if (clkEn) begin
            initSent_r <= initialSymSent;
            lreqPend_r <= linkReqPending;
            linkRst_r  <= linkReset;
        end
    end

    // ****************************************************************
    // debug bus, recovery and cause
    // ****************************************************************
    recovery_t           recovery_r;
    logic [`CAUSE_W-1:0] cause_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            recovery_r <= '0;
        end else if (clkEn) begin
            recovery_r <= recovery;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_r <= '0;
        end else if (clkEn) begin
            cause_r <= notAcceptCause;
        end
    end

    // ****************************************************************
    // debug bus, error detect and framing
    // ****************************************************************
    errDetect_t errDet_r;
    rxFraming_t framing_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            errDet_r <= '0;
        end else if (clkEn) begin
            errDet_r <= errDetect;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            framing_r <= '0;
        end else if (clkEn) begin
            framing_r <= outboundLinkManagerRx;
        end
    end

    // ****************************************************************
    // debug bus assembly
    // ****************************************************************
    // registers keep probe fan-out off the link timing paths;
    // single-cycle events seen while clkEn is low are not held
    always_comb begin
        phyDebug                            = `DBG_RST;
        phyDebug[`DBG_IDLE2]                = idleSel_r[0];
        phyDebug[`DBG_MODE_1X]              = oneLane_r;
        phyDebug[`DBG_IDLE1]                = idleSel_r[1];
        phyDebug[`DBG_PORT_INIT]            = portDbg_r;
        phyDebug[`DBG_RX_LANE_R]            = redundant_r;
        phyDebug[`DBG_CHBOND_EN]            = bondEn_r;
        phyDebug[`DBG_ALIGN_LO +: `LANES]   = align_r;
        phyDebug[`DBG_COMMA_LO +: `COMMA_W] = comma_r;
        phyDebug[`DBG_INHIBIT_LO +: `LANES] = inhibit_r;
        phyDebug[`DBG_RX_RST_REQ]           = laneFlags_r[0];
        phyDebug[`DBG_NX_ALIGNED]           = laneFlags_r[1];
        phyDebug[`DBG_NX_READY]             = laneFlags_r[2];
        phyDebug[`DBG_1X_DETECT]            = laneFlags_r[3];
        phyDebug[`DBG_STATE_LO +: 4]        = {1'b0, state_r};
        phyDebug[`DBG_OUT_SYNC]             = outOfSync_r;
        phyDebug[`DBG_SENT_LO +: 7]         = sent_r;
        phyDebug[`DBG_INIT_SENT]            = initSent_r;
        phyDebug[`DBG_SEND_LREQ]            = lreqPend_r;
        phyDebug[`DBG_LINK_RST]             = linkRst_r;
        phyDebug[`DBG_STOP_LO +: 8]         = recovery_r;
        phyDebug[`DBG_CAUSE_LO +: `CAUSE_W] = cause_r;
        phyDebug[`DBG_ERRDET_LO +: 4]       = errDet_r;
        phyDebug[`DBG_FRAME_LO +: 4]        = framing_r;
    end

endmodule

// file: phy_status_debug_observer_chk.sv
// observer output assertions
`timescale 1ns/1ns
module phy_status_debug_observer_chk
    import phy_status_pkg::*;
#(parameter bit SIM_BUILD = 1'b0) (
    input wire logic         sys_clk,
    input wire logic         rst_n,
    input wire logic         clkEn,
    input wire logic         singleLaneConfigured,
    input wire logic         portInitialized,
    input wire logic         linkInitialized,
    input wire logic         clockLocked,
    input wire initState_t   initState,
    input wire laneStatus_t  laneStatus,
    input wire ctrlSymSent_t ctrlSymSent,
    input wire logic [7:0]   status_lamp_bank,
    input wire logic [223:0] phyDebug
);
    // ******
    // checks
    // ******
    logic enPrev_r;
    // only an edge after an enabled edge carries fresh values
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            enPrev_r <= 1'b0;
        end else begin
            enPrev_r <= clkEn;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_orient; status_lamp_bank[1:0] == 2'b11; endproperty
    a_orient: assert property (p_orient) else $error("orient");
    property p_hw; !SIM_BUILD |-> status_lamp_bank[7:6] == 2'b00; endproperty
    a_hw: assert property (p_hw) else $error("sim lamps");
    property p_lamp; enPrev_r |-> status_lamp_bank[5:2] == {$past(clockLocked),
        $past(linkInitialized) & $past(portInitialized), $past(portInitialized),
        $past(singleLaneConfigured)}; endproperty
    a_lamp: assert property (p_lamp) else $error("lamps");
    property p_link; status_lamp_bank[4] |-> status_lamp_bank[3] && phyDebug[3]; endproperty
    a_link: assert property (p_link) else $error("link");
    property p_state; enPrev_r |-> phyDebug[41:38] == {1'b0, $past(initState)}
        && phyDebug[4] == ($past(initState) == INIT_SINGLE_LANE_REDUNDANT); endproperty
    a_state: assert property (p_state) else $error("state");
    property p_bond; enPrev_r |-> phyDebug[5] == &$past(laneStatus.laneSync); endproperty
    a_bond: assert property (p_bond) else $error("bond");
    property p_sent; enPrev_r |-> phyDebug[102:96] == $past(ctrlSymSent); endproperty
    a_sent: assert property (p_sent) else $error("sent");
    property p_zero; phyDebug[9:6] == 4'h0 && phyDebug[95:43] == 53'h0
        && phyDebug[159:106] == 54'h0 && phyDebug[191:168] == 24'h0
        && phyDebug[223:205] == 19'h0; endproperty
    a_zero: assert property (p_zero) else $error("spare");
    c_link: cover property (status_lamp_bank[4]);
    c_redund: cover property (phyDebug[4]);
    c_hold: cover property (!clkEn ##1 !clkEn);
endmodule
bind phy_status_debug_observer phy_status_debug_observer_chk #(.SIM_BUILD(SIM_BUILD)) chk_u (.*);

// file: lamp_probe_model.sv
// board lamp probe
`timescale 1ns/1ns
module lamp_probe_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] status_lamp_bank,
    output logic [7:0]      seenLamps
);
    // lamps only show settled levels
    always_ff @(posedge sys_clk) begin
        seenLamps <= status_lamp_bank;
    end
endmodule

// file: phy_status_debug_observer_tb.sv
// observer self-checking bench
`timescale 1ns/1ns
module phy_status_debug_observer_tb;
    import phy_status_pkg::*;
    logic sys_clk, rst_n, clkEn, singleLaneConfigured, portInitialized, linkInitialized;
    logic clockLocked, simSelfCheckErr, simExerciseDone, idle2Selected, idle1Selected;
    logic initialSymSent, linkReqPending, linkReset;
    initState_t initState;
    laneStatus_t laneStatus;
    ctrlSymSent_t ctrlSymSent;
    recovery_t recovery;
    logic [4:0] notAcceptCause;
    errDetect_t errDetect;
    rxFraming_t outboundLinkManagerRx;
    logic [7:0] status_lamp_bank;
    logic [223:0] phyDebug;
    logic [7:0] seenLamps, simLamps;
    int n_errors = 0;
    int cmp_count = 0;
    phy_status_debug_observer dut_u (.*);
    // second copy built for simulation, to see the self-check lamps
    phy_status_debug_observer #(.SIM_BUILD(1'b1)) simDut_u (.*, .status_lamp_bank(simLamps),
        .phyDebug());
    lamp_probe_model probe_u (.sys_clk, .status_lamp_bank, .seenLamps(seenLamps));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ******
    // tasks
    // ******
    task automatic check(input logic [223:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [223:0] expDbg();
        logic [223:0] e;
        e = 224'h0;
        e[5:0] = {&laneStatus.laneSync, initState == INIT_SINGLE_LANE_REDUNDANT,
            portInitialized, idle1Selected, initState >= INIT_SINGLE_LANE_ZERO, idle2Selected};
        e[33:10] = {laneStatus.txInhibit, laneStatus.charIsComma, laneStatus.chanAligned};
        e[42:34] = {laneStatus.outOfSync, 1'b0, initState, laneStatus.oneLaneDetect,
            laneStatus.nxReady, laneStatus.nxAligned, laneStatus.rxResetReq};
        e[105:96] = {linkReset, linkReqPending, initialSymSent, ctrlSymSent};
        e[167:160] = recovery;
        e[204:192] = {outboundLinkManagerRx, errDetect, notAcceptCause};
        return e;
    endfunction
    function automatic logic [7:0] expLamp(input bit sim);
        return {sim & simExerciseDone, sim & simSelfCheckErr, clockLocked,
            linkInitialized & portInitialized, portInitialized, singleLaneConfigured, 2'b11};
    endfunction
    // registered, so inputs of one edge show after it
    task automatic step();
        @(posedge sys_clk);
        #1;
        check(status_lamp_bank, expLamp(1'b0));
        check(simLamps, expLamp(1'b1));
        check(phyDebug, expDbg());
    endtask
    task automatic s_lamps();
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            {singleLaneConfigured, portInitialized, linkInitialized, clockLocked} <= i[3:0];
            step();
        end
    endtask
    task automatic s_states();
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            initState <= initState_t'(i);
            laneStatus.laneSync <= (i == 7) ? 4'hF : i[3:0];
            step();
        end
    endtask
    // walking one then all ones, back to back
    task automatic s_fields();
        for (int i = 0; i < 69; i++) begin
            @(posedge sys_clk);
            {laneStatus, ctrlSymSent, recovery, notAcceptCause, errDetect,
             outboundLinkManagerRx, idle2Selected, idle1Selected, initialSymSent,
             linkReqPending, linkReset, simSelfCheckErr, simExerciseDone}
                <= (i < 68) ? 68'h1 << i : ~68'h0;
            step();
        end
    endtask
    task automatic s_hold();
        logic [7:0] l;
        logic [223:0] d;
        l = status_lamp_bank;
        d = expDbg();
        @(posedge sys_clk);
        clkEn <= 1'b0;
        portInitialized <= ~portInitialized;
        repeat (3) @(posedge sys_clk);
        #1;
        check(phyDebug, d);
        check(status_lamp_bank, l);
        check(seenLamps, l);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        step();
    endtask
    task automatic s_reset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        #1;
        check(status_lamp_bank, 8'h03);
        check(phyDebug, 224'h0);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        check(status_lamp_bank, 8'h03);
        step();
    endtask
    initial begin
        {rst_n, clkEn, singleLaneConfigured, portInitialized, linkInitialized, clockLocked,
         simSelfCheckErr, simExerciseDone, idle2Selected, idle1Selected, initialSymSent,
         linkReqPending, linkReset, laneStatus, ctrlSymSent, recovery, notAcceptCause,
         errDetect, outboundLinkManagerRx} = '0;
        initState = INIT_SILENT;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        clkEn <= 1'b1;
        s_lamps();
        s_states();
        s_fields();
        s_hold();
        s_reset();
        summarize();
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        n_errors++;
        summarize();
    end
endmodule
